/* logic/eqpc_top.sv */
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module eqpc_top (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Settings held outside this block.
    input wire logic global_prio_ctrl,
    input wire logic port2_queue3_sel,
    input wire logic port2_two_queue,
    input wire logic port3_two_queue,
    // Port 2 egress queues.
    input wire logic [3:0] port2_pending,
    input wire logic port2_slot,
    output logic [3:0] port2_grant,
    output logic port2_grant_valid,
    output logic port2_weighted,
    // Port 3 egress queues.
    input wire logic [3:0] port3_pending,
    input wire logic port3_slot,
    output logic [3:0] port3_grant,
    output logic port3_grant_valid,
    output logic port3_weighted
);
    // ========================================================================
    // Address decode.
    // ========================================================================
    function automatic logic [3:0] reg_slot(input logic [31:0] addr);
        logic [3:0] slot;
        slot = eqpc_pkg::SLOT_NONE;
        for (int i = 0; i < eqpc_pkg::NUM_REGS; i++)
        begin
            if (addr == {22'h000000, eqpc_pkg::REG_IDX[i], 2'h0})
            begin
                slot = 4'(i);
            end
        end
        if (addr == {22'h000000, eqpc_pkg::IDX_STATUS, 2'h0})
        begin
            slot = eqpc_pkg::SLOT_STATUS;
        end
        return slot;
    endfunction

    // ========================================================================
    // Bus state.
    // ========================================================================
    logic wr_pend;
    logic next_wr_pend;
    logic [3:0] wr_slot;
    logic [3:0] next_wr_slot;
    logic [31:0] next_hrdata;
    logic [7:0] reg_val [eqpc_pkg::NUM_REGS];
    logic [eqpc_pkg::NUM_REGS-1:0] wr_en;
    logic accept;
    logic next_p2_weighted;
    logic next_p3_weighted;

    assign accept = hsel && hready && htrans[1];

    // Writes land at the end of the data phase; a read in that same cycle
    // sees the new select bit through forwarding.
    always_comb
    begin
        logic [3:0] rslot;
        logic [7:0] val;
        rslot = reg_slot(haddr);
        val = 8'h00;
        next_wr_pend = accept && hwrite;
        next_wr_slot = accept ? rslot : eqpc_pkg::SLOT_NONE;
        next_hrdata = hrdata;
        if (accept && !hwrite)
        begin
            if (rslot == eqpc_pkg::SLOT_STATUS)
            begin
                val[eqpc_pkg::ST_P2_WEIGHTED] = port2_weighted;
                val[eqpc_pkg::ST_P3_WEIGHTED] = port3_weighted;
            end
            else if (rslot != eqpc_pkg::SLOT_NONE)
            begin
                val = reg_val[rslot[2:0]];
                if (wr_pend && (wr_slot == rslot))
                begin
                    val[eqpc_pkg::SEL_BIT] = hwdata[eqpc_pkg::SEL_BIT];
                end
            end
            next_hrdata = {24'h000000, val};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_slot <= eqpc_pkg::SLOT_NONE;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= eqpc_pkg::HRESP_OKAY;
        end
        else
        begin
            wr_pend <= next_wr_pend;
            wr_slot <= next_wr_slot;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= eqpc_pkg::HRESP_OKAY;
        end
    end

    // ========================================================================
    // Queue-share registers.
    // ========================================================================
    generate
        for (genvar g = 0; g < eqpc_pkg::NUM_REGS; g++)
        begin : gen_reg
            assign wr_en[g] = wr_pend && (wr_slot == 4'(g));
            eqpc_share_reg #(
                .RSVD(eqpc_pkg::RSVD_INIT[g])
            ) u_reg (
                .clk(hclk),
                .rstn(hresetn),
                .wr_en(wr_en[g]),
                .wr_sel(hwdata[eqpc_pkg::SEL_BIT]),
                .value(reg_val[g])
            );
        end
    endgenerate

    // ========================================================================
    // Mode selection per port.
    // ========================================================================
    always_comb
    begin
        logic [3:0] p2_sel;
        logic [3:0] p3_sel;
        p2_sel = {port2_queue3_sel, reg_val[0][eqpc_pkg::SEL_BIT],
                  reg_val[1][eqpc_pkg::SEL_BIT],
                  reg_val[2][eqpc_pkg::SEL_BIT]};
        p3_sel = {reg_val[3][eqpc_pkg::SEL_BIT],
                  reg_val[4][eqpc_pkg::SEL_BIT],
                  reg_val[5][eqpc_pkg::SEL_BIT],
                  reg_val[6][eqpc_pkg::SEL_BIT]};
        next_p2_weighted = !((p2_sel == 4'h0) && !global_prio_ctrl);
        next_p3_weighted = !((p3_sel == 4'h0) && !global_prio_ctrl);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            port2_weighted <= eqpc_pkg::SEL_RESET;
            port3_weighted <= eqpc_pkg::SEL_RESET;
        end
        else
        begin
            port2_weighted <= next_p2_weighted;
            port3_weighted <= next_p3_weighted;
        end
    end

    // ========================================================================
    // Schedulers.
    // ========================================================================
    eqpc_sched_if p2_if ();
    eqpc_sched_if p3_if ();

    assign p2_if.weighted = port2_weighted;
    assign p2_if.two_queue = port2_two_queue;
    assign p2_if.slot = port2_slot;
    assign p2_if.pending = port2_pending;
    assign p2_if.weight = {eqpc_pkg::RSVD_Q3, reg_val[0][6:0],
                           reg_val[1][6:0], reg_val[2][6:0]};

    assign p3_if.weighted = port3_weighted;
    assign p3_if.two_queue = port3_two_queue;
    assign p3_if.slot = port3_slot;
    assign p3_if.pending = port3_pending;
    assign p3_if.weight = {reg_val[3][6:0], reg_val[4][6:0],
                           reg_val[5][6:0], reg_val[6][6:0]};

    eqpc_sched u_p2_sched (
        .clk(hclk),
        .rstn(hresetn),
        .sif(p2_if)
    );

    eqpc_sched u_p3_sched (
        .clk(hclk),
        .rstn(hresetn),
        .sif(p3_if)
    );

    assign port2_grant = p2_if.grant;
    assign port2_grant_valid = p2_if.grant_valid;
    assign port3_grant = p3_if.grant;
    assign port3_grant_valid = p3_if.grant_valid;
endmodule

`default_nettype wire

/* logic/eqpc_pkg.sv */
package eqpc_pkg;

    // ========================================================================
    // Register map: printed offsets are register indices, byte address = 4x.
    // ========================================================================
    localparam int unsigned NUM_REGS = 7;
    localparam logic [7:0] IDX_P2_Q2 = 8'hB4;
    localparam logic [7:0] IDX_P2_Q1 = 8'hB5;
    localparam logic [7:0] IDX_P2_Q0 = 8'hB6;
    localparam logic [7:0] IDX_P3_Q3 = 8'hB7;
    localparam logic [7:0] IDX_P3_Q2 = 8'hB8;
    localparam logic [7:0] IDX_P3_Q1 = 8'hB9;
    localparam logic [7:0] IDX_P3_Q0 = 8'hBA;
    localparam logic [7:0] IDX_STATUS = 8'hC8;
    localparam logic [7:0] REG_IDX [NUM_REGS] = '{
        IDX_P2_Q2, IDX_P2_Q1, IDX_P2_Q0,
        IDX_P3_Q3, IDX_P3_Q2, IDX_P3_Q1, IDX_P3_Q0};

    // ========================================================================
    // Field layout and reset values.
    // ========================================================================
    localparam int unsigned SEL_BIT = 7;
    localparam logic SEL_RESET = 1'b1;
    localparam logic [6:0] RSVD_Q3 = 7'h08;
    localparam logic [6:0] RSVD_Q2 = 7'h04;
    localparam logic [6:0] RSVD_Q1 = 7'h02;
    localparam logic [6:0] RSVD_Q0 = 7'h01;
    localparam logic [6:0] RSVD_INIT [NUM_REGS] = '{
        RSVD_Q2, RSVD_Q1, RSVD_Q0,
        RSVD_Q3, RSVD_Q2, RSVD_Q1, RSVD_Q0};
    localparam logic [6:0] WEIGHT_PAIR_HI = 7'h02;
    localparam logic [6:0] WEIGHT_PAIR_LO = 7'h01;

    // Status register fields.
    localparam int unsigned ST_P2_WEIGHTED = 0;
    localparam int unsigned ST_P3_WEIGHTED = 1;

    // ========================================================================
    // AHB-Lite encodings.
    // ========================================================================
    localparam logic [3:0] SLOT_STATUS = 4'h7;
    localparam logic [3:0] SLOT_NONE = 4'hF;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

/* logic/eqpc_sched_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface eqpc_sched_if;
    logic weighted;
    logic two_queue;
    logic slot;
    logic [3:0] pending;
    logic [3:0][6:0] weight;
    logic [3:0] grant;
    logic grant_valid;

    modport ctl (
        output weighted,
        output two_queue,
        output slot,
        output pending,
        output weight,
        input grant,
        input grant_valid
    );

    modport sch (
        input weighted,
        input two_queue,
        input slot,
        input pending,
        input weight,
        output grant,
        output grant_valid
    );
endinterface

`default_nettype wire

/* logic/eqpc_share_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module eqpc_share_reg #(
    parameter logic [6:0] RSVD = 7'h00
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Write side.
    input wire logic wr_en,
    input wire logic wr_sel,
    // Register contents.
    output logic [7:0] value
);
    logic sel;
    logic next_sel;

    always_comb
    begin
        next_sel = sel;
        if (wr_en)
        begin
            next_sel = wr_sel;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sel <= eqpc_pkg::SEL_RESET;
        end
        else
        begin
            sel <= next_sel;
        end
    end

    // The low field is a constant and ignores every write.
    assign value = {sel, RSVD};
endmodule

`default_nettype wire

/* logic/eqpc_sched.sv */
`timescale 1ns/1ps
`default_nettype none

module eqpc_sched (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Scheduling request and grant.
    eqpc_sched_if.sch sif
);
    logic [3:0][6:0] credit;
    logic [3:0][6:0] next_credit;
    logic [3:0] grant;
    logic [3:0] next_grant;
    logic grant_valid;
    logic next_grant_valid;

    function automatic logic [3:0] pick_high(input logic [3:0] req);
        logic [3:0] one;
        one = 4'h0;
        if (req[3])
            one = 4'h8;
        else if (req[2])
            one = 4'h4;
        else if (req[1])
            one = 4'h2;
        else if (req[0])
            one = 4'h1;
        return one;
    endfunction

    always_comb
    begin
        logic [3:0] req;
        logic [3:0] elig;
        logic [3:0] pick;
        logic [3:0][6:0] load;
        req = sif.pending & (sif.two_queue ? 4'h3 : 4'hF);
        elig = 4'h0;
        pick = 4'h0;
        load = sif.weight;
        if (sif.two_queue)
        begin
            load = {7'h00, 7'h00, eqpc_pkg::WEIGHT_PAIR_HI,
                    eqpc_pkg::WEIGHT_PAIR_LO};
        end
        next_credit = credit;
        next_grant = grant;
        next_grant_valid = 1'b0;
        if (sif.slot && (req != 4'h0))
        begin
            if (!sif.weighted)
            begin
                pick = pick_high(req);
            end
            else
            begin
                for (int i = 0; i < 4; i++)
                begin
                    elig[i] = req[i] && (credit[i] != 7'h00);
                end
                // A spent round reloads every queue, keeping the ratio.
                if (elig == 4'h0)
                begin
                    next_credit = load;
                    elig = req;
                end
                pick = pick_high(elig);
                for (int i = 0; i < 4; i++)
                begin
                    if (pick[i] && (next_credit[i] != 7'h00))
                    begin
                        next_credit[i] = next_credit[i] - 7'h01;
                    end
                end
            end
            next_grant = pick;
            next_grant_valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            credit <= '0;
            grant <= 4'h0;
            grant_valid <= 1'b0;
        end
        else
        begin
            credit <= next_credit;
            grant <= next_grant;
            grant_valid <= next_grant_valid;
        end
    end

    assign sif.grant = grant;
    assign sif.grant_valid = grant_valid;
endmodule

`default_nettype wire

/* tb/eqpc_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module eqpc_top_monitor (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus answer.
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Mode inputs.
    input wire logic global_prio_ctrl,
    input wire logic port2_queue3_sel,
    input wire logic port2_two_queue,
    input wire logic port3_two_queue,
    // Port 2.
    input wire logic [3:0] port2_grant,
    input wire logic port2_grant_valid,
    input wire logic port2_weighted,
    // Port 3.
    input wire logic [3:0] port3_pending,
    input wire logic port3_slot,
    input wire logic [3:0] port3_grant,
    input wire logic port3_grant_valid,
    input wire logic port3_weighted
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_bus_okay;
        hreadyout && hresp == 1'b0 && hrdata[31:8] == 24'h0;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus answer bad");
    property p_reset_weighted;
        $rose(hresetn) |-> port2_weighted && port3_weighted;
    endproperty
    a_reset_weighted: assert property (p_reset_weighted)
        else $error("mode after reset not weighted");
    property p_global_weighted;
        global_prio_ctrl [*2] |=> port3_weighted;
    endproperty
    a_global_weighted: assert property (p_global_weighted)
        else $error("global bit did not force weighted");
    property p_sel3_weighted;
        port2_queue3_sel [*2] |=> port2_weighted;
    endproperty
    a_sel3_weighted: assert property (p_sel3_weighted)
        else $error("queue 3 select did not force weighted");
    property p_grant_cause;
        port3_grant_valid |-> $past(port3_slot) && $past(port3_pending) != 0;
    endproperty
    a_grant_cause: assert property (p_grant_cause)
        else $error("grant without slot and pending");
    property p_grant_onehot;
        port2_grant_valid |-> $onehot(port2_grant);
    endproperty
    a_grant_onehot: assert property (p_grant_onehot)
        else $error("grant not one-hot");
    property p_strict;
        !port3_weighted && !port3_two_queue && port3_slot && port3_pending != 0
        |=> port3_grant_valid && (port3_grant & $past(port3_pending)) != 0
            && {1'b0, $past(port3_pending)} < {port3_grant, 1'b0};
    endproperty
    a_strict: assert property (p_strict)
        else $error("strict grant not highest queue");
    property p_two_queue;
        port2_grant_valid && $past(port2_two_queue) |-> port2_grant[3:2] == 2'b00;
    endproperty
    a_two_queue: assert property (p_two_queue)
        else $error("upper queue granted in two-queue mode");
endmodule

bind eqpc_top eqpc_top_monitor i_eqpc_top_monitor (.*);

`default_nettype wire

/* tb/eqpc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module eqpc_top_tb;
    localparam logic [3:0][7:0] W4 = {1'b0, eqpc_pkg::RSVD_Q3,
        1'b0, eqpc_pkg::RSVD_Q2, 1'b0, eqpc_pkg::RSVD_Q1,
        1'b0, eqpc_pkg::RSVD_Q0};
    localparam logic [3:0][7:0] W2 = {16'h0, 1'b0, eqpc_pkg::WEIGHT_PAIR_HI,
        1'b0, eqpc_pkg::WEIGHT_PAIR_LO};
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hready, hreadyout, hresp;
    logic global_prio_ctrl = 1'b0, port2_queue3_sel = 1'b1;
    logic port2_two_queue = 1'b0, port3_two_queue = 1'b0;
    logic port2_slot = 1'b0, port3_slot = 1'b0;
    logic [3:0] port2_pending = 4'h0, port3_pending = 4'h0;
    logic [3:0] port2_grant, port3_grant;
    logic port2_grant_valid, port3_grant_valid, port2_weighted, port3_weighted;
    int failures = 0, cmp_count = 0;
    int c2 [4];
    int c3 [4];

    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    eqpc_top i_eqpc_top (.*);

    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge hclk);
        end
        if (n == 50)
            failures++;
    endtask
    task automatic bus(input logic w, input logic [7:0] idx,
        input logic [31:0] d);
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic slots(input int n);
        c2 = '{default: 0};
        c3 = '{default: 0};
        port2_slot <= 1'b1;
        port3_slot <= 1'b1;
        repeat (n)
        begin
            @(posedge hclk);
            #1;
            for (int q = 0; q < 4; q++)
            begin
                c2[q] += int'(port2_grant_valid === 1'b1 && port2_grant[q]);
                c3[q] += int'(port3_grant_valid === 1'b1 && port3_grant[q]);
            end
        end
        port2_slot <= 1'b0;
        port3_slot <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    task automatic chk_cnt(input logic [3:0][7:0] e2, e3);
        for (int q = 0; q < 4; q++)
        begin
            chk($sformatf("port2 q%0d grants", q), {24'h0, e2[q]}, c2[q]);
            chk($sformatf("port3 q%0d grants", q), {24'h0, e3[q]}, c3[q]);
        end
    endtask
    task automatic chk_mode(input logic e2, e3);
        repeat (3) @(posedge hclk);
        #1;
        chk("port2 weighted", {31'h0, e2}, {31'h0, port2_weighted});
        chk("port3 weighted", {31'h0, e3}, {31'h0, port3_weighted});
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ========================================================================
    // Tests
    // ========================================================================
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        chk_mode(1'b1, 1'b1);
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, eqpc_pkg::REG_IDX[i], 32'h0);
            chk("reset value", {24'h0, eqpc_pkg::SEL_RESET,
                eqpc_pkg::RSVD_INIT[i]}, rd);
        end
        $display("test reset done");
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b1, eqpc_pkg::REG_IDX[i], 32'hFFFF_FF7F);
            bus(1'b0, eqpc_pkg::REG_IDX[i], 32'h0);
            chk("select cleared", {25'h0, eqpc_pkg::RSVD_INIT[i]}, rd);
        end
        bus(1'b1, 8'hBB, 32'hFFFF_FFFF);
        bus(1'b0, 8'hBB, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test access done");
        port2_queue3_sel <= 1'b0;
        port2_pending <= 4'h9;
        port3_pending <= 4'h6;
        chk_mode(1'b0, 1'b0);
        bus(1'b0, eqpc_pkg::IDX_STATUS, 32'h0);
        chk("status strict", 32'h0, rd);
        slots(3);
        chk_cnt({8'h03, 24'h0}, {8'h00, 8'h03, 16'h0});
        port2_pending <= 4'h0;
        port3_pending <= 4'h0;
        slots(2);
        chk_cnt(32'h0, 32'h0);
        global_prio_ctrl <= 1'b1;
        chk_mode(1'b1, 1'b1);
        bus(1'b0, eqpc_pkg::IDX_STATUS, 32'h0);
        chk("status global", 32'h3, rd);
        global_prio_ctrl <= 1'b0;
        $display("test strict done");
        for (int i = 0; i < 7; i++)
            bus(1'b1, eqpc_pkg::REG_IDX[i], 32'h80);
        port2_queue3_sel <= 1'b1;
        port2_pending <= 4'hF;
        port3_pending <= 4'hF;
        chk_mode(1'b1, 1'b1);
        slots(15);
        slots(15);
        chk_cnt(W4, W4);
        port2_two_queue <= 1'b1;
        port3_two_queue <= 1'b1;
        slots(3);
        slots(3);
        chk_cnt(W2, W2);
        $display("test weighted done");
        end_of_test();
    end

    initial
    begin
        #200000;
        failures++;
        end_of_test();
    end
endmodule

`default_nettype wire
